// ---- core/key_slot_use_limiter.sv ----
// Key slot store, use limiter, key derivation and SHA-256 engine on APB
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module key_slot_use_limiter
  import slot_limiter_pkg::*;
(
  input  wire logic        REF_CLK,  // Device clock, 100 MHz
  input  wire logic        NRST,     // Asynchronous reset, active low
  input  wire logic        PSEL,     // APB select
  input  wire logic        PENABLE,  // APB access phase
  input  wire logic        PWRITE,   // APB direction, high for write
  input  wire logic [7:0]  PADDR,    // APB byte address
  input  wire logic [31:0] PWDATA,   // APB write data
  output logic      [31:0] PRDATA,   // APB read data
  output logic             PREADY,   // APB ready
  output logic             PSLVERR   // APB error on unmapped address
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_LOAD  = 3'b010,
    ST_ROUND = 3'b011,
    ST_ADD   = 3'b100,
    ST_DONE  = 3'b101
  } state_t;

  state_t        state_r;
  op_t           op_r;
  logic          opt_r;
  logic [3:0]    tgt_r;
  logic [15:0]   selector_r;
  logic [3:0]    slot_idx_r;
  logic          done_r;
  logic          err_r;
  logic [255:0]  key_r [KEY_SLOTS];
  logic [15:0]   policy_r [KEY_SLOTS];
  logic [7:0]    use_map_r [LIMITED_SLOTS];
  logic [7:0]    count_r [LIMITED_SLOTS];
  logic [255:0]  scratch_r;
  logic [255:0]  result_r;
  logic [31:0]   data_in_r [8];
  logic [63:0]   lfsr_r;
  logic [63:0]   nonce_cnt_r;
  logic [511:0]  msg_r;
  logic          sel_incl_r;
  logic          blk_r;
  logic          pass_r;
  logic          hashed_r;
  logic [5:0]    t_r;
  logic [31:0]   w_r [16];
  logic [31:0]   v_r [8];
  logic [31:0]   hs_r [8];
  logic          pready_r;
  logic          pslverr_r;
  logic [31:0]   prdata_r;

  logic [3:0]    ks;
  logic          limited;
  logic          blocked;
  logic          chk_fail;
  logic          needs_key;
  logic          wr_fire;
  logic          start;
  logic [255:0]  data_in;
  logic [255:0]  digest;
  logic [31:0]   sum [8];
  logic [511:0]  blk1;
  logic [31:0]   t1;
  logic [31:0]   t2;
  logic [31:0]   w_new;
  logic [31:0]   rd_val;

  // SHA-256 helpers
  function automatic logic [31:0] rotr(input logic [31:0] x, input int n);
    return (x >> n) | (x << (32 - n));
  endfunction : rotr

  function automatic logic [31:0] sig0(input logic [31:0] x);
    return rotr(x, 7) ^ rotr(x, 18) ^ (x >> 3);
  endfunction : sig0

  function automatic logic [31:0] sig1(input logic [31:0] x);
    return rotr(x, 17) ^ rotr(x, 19) ^ (x >> 10);
  endfunction : sig1

  // Clear the highest set bit; scan runs from bit seven downward
  function automatic logic [7:0] clear_top(input logic [7:0] m);
    logic [7:0] r;
    logic       found;
    r = m;
    found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!found && m[i]) begin
        r[i] = 1'b0;
        found = 1'b1;
      end
    end
    return r;
  endfunction : clear_top

  // Address decode, shared by the error response and the write path
  function automatic logic addr_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && ((a <= ADDR_USE_MAP) ||
           (a[7:5] == PAGE_DATA_IN) || (a[7:5] == PAGE_RESULT));
  endfunction : addr_hit

  // Packed views of data buffer and digest
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      data_in[255 - 32 * i -: 32] = data_in_r[i];
      digest[255 - 32 * i -: 32] = hs_r[i];
      sum[i] = hs_r[i] + v_r[i];
    end
  end

  // Key slot in use
  // low selector bits, or target policy bits 3:0 for a derive with option
  always_comb begin
    ks = (op_r == OP_DERIVE && opt_r) ? policy_r[tgt_r][3:0] : tgt_r;
  end

  // Use-limit gate; slots 8 and up never limited
  // slots 0-7 only
  assign limited   = !ks[3] && policy_r[ks][POL_USE_LIMIT_BIT];
  assign blocked   = limited && (use_map_r[ks[2:0]] == USE_MAP_EMPTY);
  assign needs_key = (op_r == OP_KEYED) || (op_r == OP_HMAC) ||
                     (op_r == OP_DERIVE);
  assign chk_fail  = (needs_key && blocked) ||
                     (op_r == OP_DERIVE && !policy_r[tgt_r][POL_DERIVE_EN_BIT]) ||
                     (op_r == OP_WRITE && !policy_r[tgt_r][POL_WRITE_EN_BIT]);

  // Second block carries padding and, when asked, the full selector
  // all 16 selector bits
  assign blk1 = sel_incl_r ?
                {selector_r, 8'h80, 424'h0, MSG_BITS_SEL} :
                {8'h80, 440'h0, MSG_BITS_PLAIN};

  // Round arithmetic
  always_comb begin
    t1 = v_r[7] + (rotr(v_r[4], 6) ^ rotr(v_r[4], 11) ^ rotr(v_r[4], 25)) +
         ((v_r[4] & v_r[5]) ^ (~v_r[4] & v_r[6])) + SHA_K[t_r] + w_r[0];
    t2 = (rotr(v_r[0], 2) ^ rotr(v_r[0], 13) ^ rotr(v_r[0], 22)) +
         ((v_r[0] & v_r[1]) ^ (v_r[0] & v_r[2]) ^ (v_r[1] & v_r[2]));
    w_new = sig1(w_r[14]) + w_r[9] + sig0(w_r[1]) + w_r[0];
  end

  // APB write strobe and command start
  assign wr_fire = PSEL && PENABLE && PWRITE && pready_r && addr_hit(PADDR);
  assign start   = wr_fire && (PADDR == ADDR_COMMAND) &&
                   (state_r == ST_IDLE) && (PWDATA[2:0] != OP_NONE);

  // APB slave: answer one cycle into the access phase, from flops
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (PSEL && PENABLE && !pready_r) begin
      pready_r  <= 1'b1;
      pslverr_r <= !addr_hit(PADDR);
      prdata_r  <= PWRITE ? 32'h0000_0000 : rd_val;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA  = prdata_r;

  // Read mux; use map reads zero for slots 8 and up
  always_comb begin
    rd_val = 32'h0000_0000;
    if (PADDR[7:5] == PAGE_DATA_IN) begin
      rd_val = data_in_r[PADDR[4:2]];
    end else if (PADDR[7:5] == PAGE_RESULT) begin
      rd_val = result_r[255 - 32 * PADDR[4:2] -: 32];
    end else begin
      case (PADDR)
        ADDR_COMMAND:    rd_val = {23'h0, opt_r, 5'h0, op_r};
        ADDR_SELECTOR:   rd_val = {16'h0, selector_r};
        ADDR_STATUS:     rd_val = {29'h0, err_r, done_r,
                                   state_r != ST_IDLE};
        ADDR_SLOT_INDEX: rd_val = {28'h0, slot_idx_r};
        ADDR_POLICY:     rd_val = {16'h0, policy_r[slot_idx_r]};
        ADDR_USE_MAP:    rd_val = slot_idx_r[3] ? 32'h0000_0000 :
                                  {16'h0, count_r[slot_idx_r[2:0]],
                                   use_map_r[slot_idx_r[2:0]]};
        default:         rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Software-written control registers; locked while a command runs
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      op_r       <= OP_NONE;
      opt_r      <= 1'b0;
      selector_r <= 16'h0000;
      slot_idx_r <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        data_in_r[i] <= 32'h0000_0000;
      end
    end else if (wr_fire && state_r == ST_IDLE) begin
      if (PADDR == ADDR_COMMAND) begin
        op_r  <= op_t'(PWDATA[2:0]);
        opt_r <= PWDATA[CMD_OPTION_BIT];
      end
      if (PADDR == ADDR_SELECTOR) begin
        selector_r <= PWDATA[15:0];
      end
      if (PADDR == ADDR_SLOT_INDEX) begin
        slot_idx_r <= PWDATA[3:0];
      end
      if (PADDR[7:5] == PAGE_DATA_IN) begin
        data_in_r[PADDR[4:2]] <= PWDATA;
      end
    end
  end

  // Free-running generator plus nonce counter
  // counter makes nonces unique
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      lfsr_r      <= LFSR_SEED;
      nonce_cnt_r <= 64'h0;
    end else begin
      lfsr_r <= {lfsr_r[62:0],
                 lfsr_r[63] ^ lfsr_r[62] ^ lfsr_r[60] ^ lfsr_r[59]};
      if (state_r == ST_CHECK && op_r == OP_FRESH && opt_r) begin
        nonce_cnt_r <= nonce_cnt_r + 64'h1;
      end
    end
  end

  // Command sequencer and SHA-256 engine
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r    <= ST_IDLE;
      tgt_r      <= 4'h0;
      done_r     <= 1'b0;
      err_r      <= 1'b0;
      msg_r      <= 512'h0;
      sel_incl_r <= 1'b0;
      blk_r      <= 1'b0;
      pass_r     <= 1'b0;
      hashed_r   <= 1'b0;
      t_r        <= 6'h0;
      for (int i = 0; i < 16; i++) begin
        w_r[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < 8; i++) begin
        v_r[i]  <= 32'h0000_0000;
        hs_r[i] <= 32'h0000_0000;
      end
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            tgt_r   <= selector_r[3:0];
            done_r  <= 1'b0;
            err_r   <= 1'b0;
            state_r <= ST_CHECK;
          end
        end
        // Use check and bit clear happen here, before any hashing
        // reject before hashing
        ST_CHECK: begin
          blk_r    <= 1'b0;
          pass_r   <= 1'b0;
          hashed_r <= 1'b0;
          for (int i = 0; i < 8; i++) begin
            hs_r[i] <= SHA_H_INIT[255 - 32 * i -: 32];
          end
          if (chk_fail) begin
            err_r   <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_DONE;
            unique case (op_r)
              OP_FRESH: begin
                if (opt_r) begin
                  msg_r      <= {data_in, lfsr_r, nonce_cnt_r, 128'h0};
                  sel_incl_r <= 1'b0;
                  hashed_r   <= 1'b1;
                  state_r    <= ST_LOAD;
                end
              end
              OP_KEYED, OP_HMAC, OP_DERIVE: begin
                msg_r      <= {key_r[ks], scratch_r};
                sel_incl_r <= (op_r == OP_DERIVE) ||
                              (op_r == OP_KEYED && opt_r);
                hashed_r   <= 1'b1;
                state_r    <= ST_LOAD;
              end
              default: begin
              end
            endcase
          end
        end
        ST_LOAD: begin
          for (int i = 0; i < 16; i++) begin
            w_r[i] <= blk_r ? blk1[511 - 32 * i -: 32] :
                              msg_r[511 - 32 * i -: 32];
          end
          for (int i = 0; i < 8; i++) begin
            v_r[i] <= hs_r[i];
          end
          t_r     <= 6'h0;
          state_r <= ST_ROUND;
        end
        // One round per cycle; message schedule slides through w_r
        ST_ROUND: begin
          v_r[0] <= t1 + t2;
          v_r[1] <= v_r[0];
          v_r[2] <= v_r[1];
          v_r[3] <= v_r[2];
          v_r[4] <= v_r[3] + t1;
          v_r[5] <= v_r[4];
          v_r[6] <= v_r[5];
          v_r[7] <= v_r[6];
          for (int i = 0; i < 15; i++) begin
            w_r[i] <= w_r[i + 1];
          end
          w_r[15] <= w_new;
          t_r     <= t_r + 6'h1;
          if (t_r == LAST_ROUND) begin
            state_r <= ST_ADD;
          end
        end
        ST_ADD: begin
          if (!blk_r) begin
            for (int i = 0; i < 8; i++) begin
              hs_r[i] <= sum[i];
            end
            blk_r   <= 1'b1;
            state_r <= ST_LOAD;
          end else if (op_r == OP_HMAC && !pass_r) begin
            for (int i = 0; i < 8; i++) begin
              hs_r[i] <= SHA_H_INIT[255 - 32 * i -: 32];
              msg_r[255 - 32 * i -: 32] <= sum[i];
            end
            msg_r[511:256] <= key_r[ks];
            pass_r  <= 1'b1;
            blk_r   <= 1'b0;
            state_r <= ST_LOAD;
          end else begin
            for (int i = 0; i < 8; i++) begin
              hs_r[i] <= sum[i];
            end
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_r  <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Slot storage: keys, policies, use maps, counts, scratch and result
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      scratch_r <= 256'h0;
      result_r  <= 256'h0;
      for (int i = 0; i < KEY_SLOTS; i++) begin
        key_r[i]    <= 256'h0;
        policy_r[i] <= POLICY_RESET;
      end
      for (int i = 0; i < LIMITED_SLOTS; i++) begin
        use_map_r[i] <= USE_MAP_FULL;
        count_r[i]   <= COUNT_RESET;
      end
    end else begin
      // Personalization writes only while idle
      if (wr_fire && state_r == ST_IDLE) begin
        if (PADDR == ADDR_POLICY) begin
          policy_r[slot_idx_r] <= PWDATA[15:0];
        end
        if (PADDR == ADDR_USE_MAP && !slot_idx_r[3]) begin
          use_map_r[slot_idx_r[2:0]] <= PWDATA[7:0];
        end
      end
      if (state_r == ST_CHECK && !chk_fail) begin
        // Bit is spent even if the command never finishes
        // clear one bit
        if (needs_key && limited) begin
          use_map_r[ks[2:0]] <= clear_top(use_map_r[ks[2:0]]);
        end
        unique case (op_r)
          OP_FRESH: begin
            if (!opt_r) begin
              scratch_r <= data_in;
            end
          end
          OP_XOR:   result_r <= data_in ^ scratch_r;
          OP_READ:  result_r <= key_r[tgt_r];
          OP_WRITE: key_r[tgt_r] <= data_in;
          default: begin
          end
        endcase
      end
      if (state_r == ST_DONE && hashed_r) begin
        unique case (op_r)
          OP_FRESH: scratch_r <= digest;
          OP_KEYED, OP_HMAC: result_r <= digest;
          OP_DERIVE: begin
            key_r[tgt_r] <= digest;
            if (!tgt_r[3]) begin
              count_r[tgt_r[2:0]]   <= count_r[tgt_r[2:0]] + 8'h01;
              use_map_r[tgt_r[2:0]] <= USE_MAP_FULL;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule : key_slot_use_limiter

// ---- core/slot_limiter_pkg.sv ----
// Shared constants, register map and SHA-256 tables for the key slot limiter
package slot_limiter_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_COMMAND    = 8'h00;
  localparam logic [7:0] ADDR_SELECTOR   = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_SLOT_INDEX = 8'h0c;
  localparam logic [7:0] ADDR_POLICY     = 8'h10;
  localparam logic [7:0] ADDR_USE_MAP    = 8'h14;
  localparam logic [2:0] PAGE_DATA_IN    = 3'h1;  // 0x20..0x3c
  localparam logic [2:0] PAGE_RESULT     = 3'h2;  // 0x40..0x5c

  // Command register fields
  localparam int CMD_OPTION_BIT = 8;

  // Slot policy word fields
  localparam int POL_WRITE_EN_BIT  = 14;
  localparam int POL_DERIVE_EN_BIT = 13;
  localparam int POL_SECRET_BIT    = 7;
  localparam int POL_USE_LIMIT_BIT = 5;

  // Reset and marker values
  localparam logic [15:0]  POLICY_RESET  = 16'h0000;
  localparam logic [7:0]   USE_MAP_FULL  = 8'hff;
  localparam logic [7:0]   USE_MAP_EMPTY = 8'h00;
  localparam logic [7:0]   COUNT_RESET   = 8'h00;
  localparam logic [63:0]  LFSR_SEED     = 64'h0123_4567_89ab_cdef;
  localparam int           KEY_SLOTS     = 16;
  localparam int           LIMITED_SLOTS = 8;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_FRESH  = 3'b001,
    OP_KEYED  = 3'b010,
    OP_HMAC   = 3'b011,
    OP_XOR    = 3'b100,
    OP_DERIVE = 3'b101,
    OP_READ   = 3'b110,
    OP_WRITE  = 3'b111
  } op_t;

  // SHA-256 padding lengths and tables
  localparam logic [63:0] MSG_BITS_PLAIN = 64'd512;
  localparam logic [63:0] MSG_BITS_SEL   = 64'd528;
  localparam logic [5:0]  LAST_ROUND     = 6'd63;
  localparam logic [255:0] SHA_H_INIT = {
    32'h6a09e667, 32'hbb67ae85, 32'h3c6ef372, 32'ha54ff53a,
    32'h510e527f, 32'h9b05688c, 32'h1f83d9ab, 32'h5be0cd19};
  localparam logic [31:0] SHA_K [64] = '{
    32'h428a2f98, 32'h71374491, 32'hb5c0fbcf, 32'he9b5dba5,
    32'h3956c25b, 32'h59f111f1, 32'h923f82a4, 32'hab1c5ed5,
    32'hd807aa98, 32'h12835b01, 32'h243185be, 32'h550c7dc3,
    32'h72be5d74, 32'h80deb1fe, 32'h9bdc06a7, 32'hc19bf174,
    32'he49b69c1, 32'hefbe4786, 32'h0fc19dc6, 32'h240ca1cc,
    32'h2de92c6f, 32'h4a7484aa, 32'h5cb0a9dc, 32'h76f988da,
    32'h983e5152, 32'ha831c66d, 32'hb00327c8, 32'hbf597fc7,
    32'hc6e00bf3, 32'hd5a79147, 32'h06ca6351, 32'h14292967,
    32'h27b70a85, 32'h2e1b2138, 32'h4d2c6dfc, 32'h53380d13,
    32'h650a7354, 32'h766a0abb, 32'h81c2c92e, 32'h92722c85,
    32'ha2bfe8a1, 32'ha81a664b, 32'hc24b8b70, 32'hc76c51a3,
    32'hd192e819, 32'hd6990624, 32'hf40e3585, 32'h106aa070,
    32'h19a4c116, 32'h1e376c08, 32'h2748774c, 32'h34b0bcb5,
    32'h391c0cb3, 32'h4ed8aa4a, 32'h5b9cca4f, 32'h682e6ff3,
    32'h748f82ee, 32'h78a5636f, 32'h84c87814, 32'h8cc70208,
    32'h90befffa, 32'ha4506ceb, 32'hbef9a3f7, 32'hc67178f2};
endpackage : slot_limiter_pkg

// ---- bench/key_slot_use_limiter_props.sv ----
// Concurrent checks on the APB ports of the key slot use limiter
`timescale 1ns/1ps
module slot_limiter_props
  import slot_limiter_pkg::*;
(
  input wire logic        REF_CLK, // Device clock
  input wire logic        NRST,    // Reset, active low
  input wire logic        PSEL,    // Select
  input wire logic        PENABLE, // Access phase
  input wire logic        PWRITE,  // Direction
  input wire logic [7:0]  PADDR,   // Byte address
  input wire logic [31:0] PWDATA,  // Write data
  input wire logic [31:0] PRDATA,  // Read data
  input wire logic        PREADY,  // Ready
  input wire logic        PSLVERR  // Error
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  // Access phase and decoded address, aligned words only
  logic acc;
  logic mapped;
  assign acc = PSEL && PENABLE;
  assign mapped = (PADDR[1:0] == 2'b00) &&
    (PADDR <= ADDR_USE_MAP || (PADDR >= 8'h20 && PADDR <= 8'h5c));

  sequence wait_s;
    acc && !PREADY;
  endsequence
  sequence answer_s;
    PREADY ##1 !PREADY;
  endsequence

  // One wait state, then a single ready pulse
  pready_wait_a: assert property (wait_s |=> answer_s)
    else $error("ready pulse wrong after access");
  pready_idle_a: assert property (!acc && !PREADY |=> !PREADY)
    else $error("ready without access");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error outside ready cycle");
  unmapped_err_a: assert property (PREADY && !mapped |-> PSLVERR)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("mapped address refused");
  rdata_hold_a: assert property (!acc |=> $stable(PRDATA))
    else $error("read data moved between accesses");
  status_code_a: assert property (PREADY && !PWRITE &&
    PADDR == ADDR_STATUS |-> PRDATA[31:3] == 29'h0 && PRDATA[2:1] != 2'b11)
    else $error("status both done and error");
  // Map must stay a right-aligned run of ones
  use_map_run_a: assert property (
    PREADY && !PWRITE && PADDR == ADDR_USE_MAP |->
    (PRDATA[7:0] & (PRDATA[7:0] + 8'h01)) == 8'h00)
    else $error("use map not a run of ones");
endmodule : slot_limiter_props

bind key_slot_use_limiter slot_limiter_props u_props (
  .REF_CLK (REF_CLK),
  .NRST    (NRST),
  .PSEL    (PSEL),
  .PENABLE (PENABLE),
  .PWRITE  (PWRITE),
  .PADDR   (PADDR),
  .PWDATA  (PWDATA),
  .PRDATA  (PRDATA),
  .PREADY  (PREADY),
  .PSLVERR (PSLVERR)
);

// ---- bench/host_apb.sv ----
// Host model issuing APB transfers and command sequences
`timescale 1ns/1ps
module host_apb
  import slot_limiter_pkg::*;
(
  input  wire logic        clk,     // Device clock
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Ready
  input  wire logic        pslverr, // Error
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic      [7:0]  paddr,   // Address
  output logic      [31:0] pwdata,  // Write data
  output logic             hang     // A bounded wait ran out
);
  // Idle bus from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hang} = '0;
  end

  // One transfer, held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang = 1'b1;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Start a command, then poll status until done or error
  task automatic cmd(input logic [31:0] c, output logic [31:0] s);
    logic e;
    int n;
    n = 0;
    xfer(1'b1, ADDR_COMMAND, c, s, e);
    do begin
      xfer(1'b0, ADDR_STATUS, 32'h0, s, e);
      n++;
    end while (s[2:1] == 2'b00 && n < 400);
    if (n >= 400) hang = 1'b1;
  endtask : cmd

  // Use map written only as a run of ones
  task automatic setup_slot(input logic [3:0] k, input logic [15:0] p,
    input int uses);
    logic [31:0] q;
    logic e;
    xfer(1'b1, ADDR_SLOT_INDEX, {28'h0, k}, q, e);
    // Key slots always carry the secret marker
    xfer(1'b1, ADDR_POLICY, {16'h0, p | (16'h0001 << POL_SECRET_BIT)}, q, e);
    xfer(1'b1, ADDR_USE_MAP, 32'hff >> (8 - uses), q, e);
  endtask : setup_slot

  // Fresh value loads scratch before derivation
  task automatic derive(input logic [31:0] c, output logic [31:0] s);
    cmd(32'h1, s);
    cmd(c, s);
  endtask : derive
endmodule : host_apb

// ---- bench/key_slot_use_limiter_bench.sv ----
// Self-checking bench for the key slot use limiter
`timescale 1ns/1ps
module key_slot_use_limiter_bench
  import slot_limiter_pkg::*;
;
  logic        ref_clk;
  logic        nrst;
  logic        psel, penable, pwrite, pready, pslverr, hang, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, s;
  logic [31:0] w0;
  time         tk, th;
  int          miscompares = 0;
  int          tests_run   = 0;
  // SHA-256 of a 512-bit all-zero message: zero key with zero scratch
  localparam logic [255:0] ZERO_DIGEST =
    256'hf5a5fd42d16a20302798ef6ed309979b43003d2320d9f0e8ea9831a92759fb4b;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } row_t;
  // Register rows: reset values, readback, high slot, refusals
  row_t rows [15] = '{
    '{1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_SLOT_INDEX, 32'h5, 32'h0, 1'b0},
    '{1'b0, ADDR_POLICY, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_USE_MAP, 32'h0, 32'hff, 1'b0},
    '{1'b1, ADDR_POLICY, 32'h4020, 32'h0, 1'b0},
    '{1'b0, ADDR_POLICY, 32'h0, 32'h4020, 1'b0},
    '{1'b1, ADDR_USE_MAP, 32'h3f, 32'h0, 1'b0},
    '{1'b0, ADDR_USE_MAP, 32'h0, 32'h3f, 1'b0},
    '{1'b1, ADDR_SLOT_INDEX, 32'h9, 32'h0, 1'b0},
    '{1'b1, ADDR_USE_MAP, 32'h0f, 32'h0, 1'b0},
    '{1'b0, ADDR_USE_MAP, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_SELECTOR, 32'h1234abcd, 32'h0, 1'b0},
    '{1'b0, ADDR_SELECTOR, 32'h0, 32'habcd, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h62, 32'h0, 32'h0, 1'b1}};

  key_slot_use_limiter dut (
    .REF_CLK (ref_clk), .NRST (nrst), .PSEL (psel), .PENABLE (penable),
    .PWRITE (pwrite), .PADDR (paddr), .PWDATA (pwdata),
    .PRDATA (prdata), .PREADY (pready), .PSLVERR (pslverr));
  host_apb u_host (
    .clk (ref_clk), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .psel (psel), .penable (penable),
    .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .hang (hang));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic differ(input logic [31:0] a, input logic [31:0] b);
    tests_run++;
    if (a === b) begin
      miscompares++;
      $display("CHECK FAILED %0t values should differ %h", $time, a);
    end
  endtask : differ
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // A hung wait counts as a mismatch and ends the run
  initial begin
    wait (hang === 1'b1);
    miscompares++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      u_host.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
      if (!rows[i].w) check(q, rows[i].q);
      check({31'h0, e}, {31'h0, rows[i].e});
    end
    $display("register rows done");
    // Two uses on slot 3, upper selector bits set, then exhausted
    u_host.setup_slot(4'h3, 16'h0020, 2);
    wr(ADDR_SELECTOR, 32'hfff3);
    for (int k = 0; k < 3; k++) begin
      u_host.cmd(32'h2, s);
      check(s, (k < 2) ? 32'h2 : 32'h4);
      rd(ADDR_USE_MAP);
      check(q, (k == 0) ? 32'h1 : 32'h0);
    end
    // Refused third use left the last digest in place
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h40 + 4 * i));
      check(q, ZERO_DIGEST[255 - 32 * i -: 32]);
    end
    u_host.cmd(32'h6, s);
    check(s, 32'h2);
    rd(ADDR_USE_MAP);
    check(q, 32'h0);
    $display("use limit test done");
    // Slot 9 ignores the limit enable
    u_host.setup_slot(4'h9, 16'h0020, 1);
    wr(ADDR_SELECTOR, 32'h9);
    repeat (2) begin
      u_host.cmd(32'h2, s);
      check(s, 32'h2);
    end
    // Upper selector bits reach the message; HMAC runs longer
    u_host.cmd(32'h102, s);
    rd(8'h40);
    w0 = q;
    wr(ADDR_SELECTOR, 32'h8009);
    tk = $time;
    u_host.cmd(32'h102, s);
    tk = $time - tk;
    rd(8'h40);
    differ(q, w0);
    th = $time;
    u_host.cmd(32'h3, s);
    th = $time - th;
    check(s, 32'h2);
    check({31'h0, th > tk}, 32'h1);
    $display("high slot test done");
    // Roll then create refresh the map and count updates
    u_host.setup_slot(4'h3, 16'h2024, 1);
    wr(ADDR_SELECTOR, 32'h3);
    for (int k = 0; k < 2; k++) begin
      u_host.derive(32'h005 | (32'(k) << 8), s);
      check(s, 32'h2);
      rd(ADDR_USE_MAP);
      check(q, 32'h1ff + 32'(k) * 32'h100);
    end
    $display("derive test done");
    // Scratch from data, then XOR with new data
    for (int i = 0; i < 8; i++) wr(8'(8'h20 + 4 * i), 32'h01010101 * i);
    u_host.cmd(32'h1, s);
    for (int i = 0; i < 8; i++) wr(8'(8'h20 + 4 * i), 32'h5a5a5a5a);
    u_host.cmd(32'h4, s);
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h40 + 4 * i));
      check(q, 32'h5a5a5a5a ^ (32'h01010101 * i));
    end
    // Two random nonces from one challenge differ
    for (int r = 0; r < 2; r++) begin
      w0 = q;
      u_host.cmd(32'h101, s);
      u_host.cmd(32'h4, s);
      rd(8'h40);
    end
    differ(q, w0);
    $display("xor test done");
    // Key write refused, then allowed by the write enable bit
    wr(ADDR_SELECTOR, 32'h4);
    for (int p = 0; p < 2; p++) begin
      u_host.setup_slot(4'h4, (p == 1) ? 16'h4000 : 16'h0000, 8);
      u_host.cmd(32'h7, s);
      check(s, (p == 1) ? 32'h2 : 32'h4);
    end
    u_host.cmd(32'h6, s);
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h40 + 4 * i));
      check(q, 32'h5a5a5a5a);
    end
    $display("key write test done");
    // Mid-run reset restores status, maps and counts
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_STATUS);
    check(q, 32'h0);
    wr(ADDR_SLOT_INDEX, 32'h3);
    rd(ADDR_USE_MAP);
    check(q, 32'hff);
    $display("reset test done");
    stop_test();
  end
endmodule : key_slot_use_limiter_bench
